// file: port_pin_defines.svh
// offsets, field positions and reset values of the port pin block
// assumes an 8-bit special function register space with page select
`ifndef PORT_PIN_DEFINES_SVH
`define PORT_PIN_DEFINES_SVH

// ***************************************
// register addresses
// ***************************************
`define PORT1_DATA_LATCH_ADDR 8'h90
`define PORT2_DATA_LATCH_ADDR 8'hA0
`define PORT3_DATA_LATCH_ADDR 8'hB0
`define PORT4_DATA_LATCH_ADDR 8'hC8
`define PORT1_OUTPUT_MODE_ADDR 8'hA5
`define PORT2_OUTPUT_MODE_ADDR 8'hA6
`define PORT3_OUTPUT_MODE_ADDR 8'hA7
`define PORT4_OUTPUT_MODE_ADDR 8'h9C
`define PORT1_INPUT_MODE_ADDR 8'hAD
`define PORT2_INPUT_MODE_ADDR 8'hAE
`define PORT3_INPUT_MODE_ADDR 8'hAF
`define CROSSBAR_CONFIG_2_ADDR 8'hE3
`define PAGE_F 8'h0F

// ***************************************
// fields and reset values
// ***************************************
`define PULLUP_DISABLE_BIT 7
`define EXTMEM_LOW_PORT_ENABLE_BIT 1
`define CROSSBAR_CONFIG_2_MASK 8'hDF
`define DATA_LATCH_RESET 8'hFF
`define INPUT_MODE_RESET 8'hFF
`define OUTPUT_MODE_RESET 8'h00
`define CROSSBAR_CONFIG_2_RESET 8'h00

`endif

// file: port_pin_pkg.sv
// types shared by the port pin block
// assumes nothing beyond the defines header
`default_nettype none

package port_pin_pkg;

   // ***************************************
   // register access request
   // ***************************************
   typedef struct packed {
      logic rd;
      logic wr;
      logic bit_op;
      logic rmw;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   // ***************************************
   // external memory interface pin drive
   // ***************************************
   typedef struct packed {
      logic active;
      logic low_ports;
      logic muxed;
      logic read;
      logic [15:0] addr;
      logic [7:0] data;
      logic wr_n;
      logic rd_n;
      logic ale;
   } external_memory_interface_t;

   typedef logic [3:0][7:0] port_bus_t;

endpackage

`default_nettype wire

// file: port_pin_driver.sv
// one 8-bit port: pin synchroniser, driver and pullup control
// assumes pins are asynchronous to clock_in
`default_nettype none

module port_pin_driver (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] value_in,
   input wire logic [7:0] push_pull_in,
   input wire logic [7:0] digital_in,
   input wire logic [7:0] force_od_in,
   input wire logic [7:0] drive_off_in,
   input wire logic pullup_dis_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_out,
   output logic [7:0] pullup_out,
   output logic [7:0] level_out
);

   // ***************************************
   // input synchroniser and agreement filter
   // ***************************************
   logic [7:0] s1_q;
   logic [7:0] s2_q;
   logic [7:0] s3_q;
   logic [7:0] filt_q;
   wire [7:0] agree = ~(s2_q ^ s3_q);
   wire [7:0] filt_d = (agree & s3_q) | (~agree & filt_q);

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s1_q <= 8'hFF;
         s2_q <= 8'hFF;
         s3_q <= 8'hFF;
         filt_q <= 8'hFF;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   // ***************************************
   // driver and pullup
   // ***************************************
   wire [7:0] drive_low = ~value_in & ~drive_off_in;
   wire [7:0] drive_high = value_in & push_pull_in & ~force_od_in
      & ~drive_off_in;

   assign pin_out = value_in;
   assign pin_oe_out = drive_low | drive_high;
   assign pullup_out = digital_in & ~{8{pullup_dis_in}}
      & ~drive_low;
   assign level_out = filt_q & digital_in;

endmodule

`default_nettype wire

// file: port_pin_config.sv
// port latches and output modes of ports 1 to 4, input modes of ports 1 to 3
// assumes a core register bus on clock_in and pins outside the chip
//
// How it works
// - output mode 0 open-drain, 1 push-pull
// - two-wire and mode-0 receive pins forced open-drain
// - latch 0 drives low, 1 high or released
// - plain read returns pin level
// - read-modify-write read returns latch contents
// - input mode 0: analog, reads 0, pullup off
// - input mode 1: digital, pullup follows global
// - port 2 bits 0, 1 never skipped
// - reset: latches ones, inputs ones, outputs zeros
// - global disable bit switches all pullups off
// - pullup off on pins driven low
// - external memory overrides latches during moves
// - external read disables data bus drivers
// - port 2 carries external address byte
// - port 3 carries external data byte
// - port 4 bits 7..5 carry strobes, latch enable
// - port 4 digital input path always active
// - port 4 latch takes byte and bit access
// - port 1 to 3 latches any page, others page F
`default_nettype none

`include "port_pin_defines.svh"

module port_pin_config (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire port_pin_pkg::sfr_req_t sfr_in,
   output logic sfr_hit_out,
   output logic sfr_rvalid_out,
   output logic [7:0] sfr_rdata_out,
   input wire port_pin_pkg::external_memory_interface_t external_memory_interface_in,
   input wire port_pin_pkg::port_bus_t force_od_in,
   input wire port_pin_pkg::port_bus_t pin_in,
   output port_pin_pkg::port_bus_t pin_out,
   output port_pin_pkg::port_bus_t pin_oe_out,
   output port_pin_pkg::port_bus_t pullup_out,
   output port_pin_pkg::port_bus_t crossbar_skip_out
);
   import port_pin_pkg::*;

   // ***************************************
   // register map
   // ***************************************
   localparam int NREG = 12;
   localparam logic [7:0] REG_ADDR [NREG] = '{
      `PORT1_DATA_LATCH_ADDR, `PORT2_DATA_LATCH_ADDR,
      `PORT3_DATA_LATCH_ADDR, `PORT4_DATA_LATCH_ADDR,
      `PORT1_OUTPUT_MODE_ADDR, `PORT2_OUTPUT_MODE_ADDR,
      `PORT3_OUTPUT_MODE_ADDR, `PORT4_OUTPUT_MODE_ADDR,
      `PORT1_INPUT_MODE_ADDR, `PORT2_INPUT_MODE_ADDR,
      `PORT3_INPUT_MODE_ADDR, `CROSSBAR_CONFIG_2_ADDR};
   localparam logic [7:0] REG_RESET [NREG] = '{
      `DATA_LATCH_RESET, `DATA_LATCH_RESET,
      `DATA_LATCH_RESET, `DATA_LATCH_RESET,
      `OUTPUT_MODE_RESET, `OUTPUT_MODE_RESET,
      `OUTPUT_MODE_RESET, `OUTPUT_MODE_RESET,
      `INPUT_MODE_RESET, `INPUT_MODE_RESET,
      `INPUT_MODE_RESET, `CROSSBAR_CONFIG_2_RESET};
   localparam logic [7:0] REG_MASK [NREG] = '{
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      `CROSSBAR_CONFIG_2_MASK};
   // port 1 to 3 data latches sit in every page
   localparam logic [NREG-1:0] ALL_PAGES = 12'h007;
   localparam logic [NREG-1:0] BIT_ADDRESSABLE = 12'h00F;

   logic [7:0] regs_q [NREG];
   logic [7:0] regs_d [NREG];
   logic [7:0] read_val [NREG];
   logic [7:0] rd_chain [NREG+1];
   logic [NREG-1:0] byte_hit;
   logic [NREG-1:0] bit_hit;
   logic [NREG-1:0] wr_en;
   logic [7:0] level [4];
   logic [7:0] rdata_q;
   logic rvalid_q;

   wire page_f = sfr_in.page == `PAGE_F;
   wire [7:0] bit_sel = 8'h01 << sfr_in.addr[2:0];
   wire [7:0] bit_val = {8{sfr_in.wdata[0]}};

   // ***************************************
   // decode, write and read per register
   // ***************************************
   assign rd_chain[0] = 8'h00;

   for (genvar i = 0; i < NREG; i++) begin : g_reg
      wire page_ok = ALL_PAGES[i] | page_f;
      assign byte_hit[i] = page_ok & !sfr_in.bit_op
         & (sfr_in.addr == REG_ADDR[i]);
      assign bit_hit[i] = page_ok & sfr_in.bit_op & BIT_ADDRESSABLE[i]
         & (sfr_in.addr[7:3] == REG_ADDR[i][7:3]);
      assign wr_en[i] = sfr_in.wr & (byte_hit[i] | bit_hit[i]);
      assign regs_d[i] = bit_hit[i]
         ? ((regs_q[i] & ~bit_sel) | (bit_val & bit_sel))
         : (sfr_in.wdata & REG_MASK[i]);

      always_ff @(posedge clock_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            regs_q[i] <= REG_RESET[i];
         end else if (wr_en[i]) begin
            regs_q[i] <= regs_d[i];
         end
      end

      if (i < 4) begin : g_data
         // latch on read-modify-write, pin otherwise
         assign read_val[i] = sfr_in.rmw ? regs_q[i]
            : level[i];
      end else begin : g_cfg
         assign read_val[i] = regs_q[i];
      end

      wire [7:0] term = byte_hit[i] ? read_val[i]
         : bit_hit[i] ? {7'h00, read_val[i][sfr_in.addr[2:0]]}
         : 8'h00;
      assign rd_chain[i+1] = rd_chain[i] | term;
   end

   wire any_hit = |(byte_hit | bit_hit);
   assign sfr_hit_out = (sfr_in.rd | sfr_in.wr) & any_hit;

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= sfr_in.rd;
         if (sfr_in.rd) begin
            rdata_q <= rd_chain[NREG];
         end
      end
   end

   assign sfr_rdata_out = rdata_q;
   assign sfr_rvalid_out = rvalid_q;

   // ***************************************
   // configuration views
   // ***************************************
   wire pullup_dis = regs_q[11][`PULLUP_DISABLE_BIT];
   logic [7:0] in_mode [4];
   assign in_mode[0] = regs_q[8];
   assign in_mode[1] = regs_q[9];
   assign in_mode[2] = regs_q[10];
   assign in_mode[3] = 8'hFF;

   // analog pins are skipped, except port 2 bits 1..0
   assign crossbar_skip_out[0] = ~in_mode[0];
   assign crossbar_skip_out[1] = ~in_mode[1] & 8'hFC;
   assign crossbar_skip_out[2] = ~in_mode[2];
   assign crossbar_skip_out[3] = 8'h00;

   // ***************************************
   // external memory override
   // ***************************************
   wire external_memory_interface_low = external_memory_interface_in.active & external_memory_interface_in.low_ports;
   wire external_memory_interface_high = external_memory_interface_in.active & !external_memory_interface_in.low_ports;
   logic [7:0] external_memory_interface_mask [4];
   logic [7:0] external_memory_interface_val [4];
   logic [7:0] drive_off [4];

   assign external_memory_interface_mask[0] = 8'h00;
   assign external_memory_interface_val[0] = 8'h00;
   assign external_memory_interface_mask[1] = {8{external_memory_interface_low}};
   assign external_memory_interface_val[1] = external_memory_interface_in.muxed ? external_memory_interface_in.addr[15:8]
      : external_memory_interface_in.addr[7:0];
   assign external_memory_interface_mask[2] = {8{external_memory_interface_low}};
   assign external_memory_interface_val[2] = external_memory_interface_in.data;
   assign external_memory_interface_mask[3] = {external_memory_interface_high, external_memory_interface_high, external_memory_interface_high, 5'h00};
   assign external_memory_interface_val[3] = {external_memory_interface_in.wr_n, external_memory_interface_in.rd_n, external_memory_interface_in.ale,
      5'h00};

   assign drive_off[0] = 8'h00;
   assign drive_off[1] = 8'h00;
   assign drive_off[2] = {8{external_memory_interface_low & external_memory_interface_in.read}};
   assign drive_off[3] = 8'h00;

   // ***************************************
   // pin drivers
   // ***************************************
   for (genvar p = 0; p < 4; p++) begin : g_port
      wire [7:0] value = (regs_q[p] & ~external_memory_interface_mask[p])
         | (external_memory_interface_val[p] & external_memory_interface_mask[p]);
      port_pin_driver u_drv (
         .clock_in(clock_in),
         .arst_n_in(arst_n_in),
         .pin_in(pin_in[p]),
         .value_in(value),
         .push_pull_in(regs_q[p+4]),
         .digital_in(in_mode[p]),
         .force_od_in(force_od_in[p]),
         .drive_off_in(drive_off[p]),
         .pullup_dis_in(pullup_dis),
         .pin_out(pin_out[p]),
         .pin_oe_out(pin_oe_out[p]),
         .pullup_out(pullup_out[p]),
         .level_out(level[p])
      );
   end

   // ***************************************
   // checks
   // ***************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!arst_n_in);

   logic first_q;
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   wire rd_p1 = sfr_in.rd & !sfr_in.bit_op & !sfr_in.rmw
      & (sfr_in.addr == `PORT1_DATA_LATCH_ADDR);
   wire rmw_p1 = sfr_in.rd & !sfr_in.bit_op & sfr_in.rmw
      & (sfr_in.addr == `PORT1_DATA_LATCH_ADDR);
   wire wr_p1 = sfr_in.wr & !sfr_in.bit_op
      & (sfr_in.addr == `PORT1_DATA_LATCH_ADDR);
   wire bitwr_p2 = sfr_in.wr & sfr_in.bit_op
      & (sfr_in.addr[7:3] == REG_ADDR[1][7:3]);
   wire wr_p4_off = sfr_in.wr & !sfr_in.bit_op & !page_f
      & (sfr_in.addr == `PORT4_DATA_LATCH_ADDR);
   wire [7:0] p1_expect = pin_in[0] & regs_q[8];
   wire [7:0] p1_latch = regs_q[0];
   wire [7:0] p2_latch = regs_q[1];
   wire [7:0] p2_keep = ~bit_sel;
   wire rd_p3 = sfr_in.rd & !sfr_in.bit_op & !sfr_in.rmw
      & (sfr_in.addr == `PORT3_DATA_LATCH_ADDR);
   wire bitwr_p4 = sfr_in.wr & sfr_in.bit_op & page_f
      & (sfr_in.addr[7:3] == REG_ADDR[3][7:3]);
   wire wr_mode_off = sfr_in.wr & !sfr_in.bit_op & !page_f
      & (sfr_in.addr == `PORT2_OUTPUT_MODE_ADDR);
   wire [7:0] p3_mode = regs_q[10];
   wire [7:0] p4_latch = regs_q[3];

   reset_vals_a: assert property (
      first_q |-> regs_q[0] == 8'hFF && regs_q[4] == 8'h00
         && regs_q[8] == 8'hFF && regs_q[11] == 8'h00)
      else $error("reset values wrong");

   latch_drive_a: assert property (
      wr_p1 |=> pin_out[0] == $past(sfr_in.wdata)
         && (~pin_out[0] & ~pin_oe_out[0]) == 8'h00)
      else $error("written latch not on pins");

   od_release_a: assert property (
      regs_q[4] == 8'h00 |-> (pin_oe_out[0] & pin_out[0]) == 8'h00)
      else $error("open-drain pin driven high");

   force_od_a: assert property (
      (pin_oe_out[0] & pin_out[0] & force_od_in[0]) == 8'h00)
      else $error("forced open-drain pin driven high");

   pin_read_a: assert property (
      ($stable(pin_in[0]) [*5] ##0 rd_p1 && $stable(regs_q[8]))
         |=> sfr_rdata_out == $past(p1_expect))
      else $error("pin read mismatch");

   rmw_read_a: assert property (
      rmw_p1 |=> sfr_rdata_out == $past(p1_latch))
      else $error("read-modify-write did not return latch");

   pullup_low_a: assert property (
      (pullup_out[1] & pin_oe_out[1] & ~pin_out[1]) == 8'h00)
      else $error("pullup on pin driven low");

   pullup_dis_a: assert property (
      pullup_dis |-> pullup_out == '0)
      else $error("pullup on while globally disabled");

   page_guard_a: assert property (
      wr_p4_off |=> $stable(regs_q[3]))
      else $error("port 4 latch written off page");

   bit_write_a: assert property (
      bitwr_p2 && page_f |=> ((p2_latch ^ $past(p2_latch))
         & $past(p2_keep)) == 8'h00)
      else $error("bit write disturbed other bits");

   ext_read_a: assert property (
      external_memory_interface_low && external_memory_interface_in.read |-> pin_oe_out[2] == 8'h00)
      else $error("data bus driven during external read");

   strobes_a: assert property (
      external_memory_interface_high |-> pin_out[3][7:5]
         == {external_memory_interface_in.wr_n, external_memory_interface_in.rd_n, external_memory_interface_in.ale})
      else $error("strobes not on port 4");

   no_skip_a: assert property (
      crossbar_skip_out[1][1:0] == 2'h0)
      else $error("port 2 low pins skipped");

   push_pull_a: assert property (
      (regs_q[4] & regs_q[0] & ~force_od_in[0] & ~pin_oe_out[0])
         == 8'h00)
      else $error("push-pull pin not driven high");

   drive_low_a: assert property (
      !external_memory_interface_low |-> (~regs_q[1] & ~pin_oe_out[1]) == 8'h00)
      else $error("zero latch bit not driven low");

   analog_read_a: assert property (
      rd_p3 |=> (sfr_rdata_out & ~$past(p3_mode)) == 8'h00)
      else $error("analog pin read as one");

   analog_pullup_a: assert property (
      (pullup_out[2] & ~p3_mode) == 8'h00)
      else $error("pullup on analog pin");

   digital_pullup_a: assert property (
      !pullup_dis && regs_q[0] == 8'hFF |-> pullup_out[0] == regs_q[8])
      else $error("digital pullup not following global enable");

   addr_byte_a: assert property (
      external_memory_interface_low |-> pin_out[1] == (external_memory_interface_in.muxed ? external_memory_interface_in.addr[15:8]
         : external_memory_interface_in.addr[7:0]))
      else $error("address byte not on port 2");

   data_byte_a: assert property (
      external_memory_interface_low |-> pin_out[2] == external_memory_interface_in.data)
      else $error("data byte not on port 3");

   latch_kept_a: assert property (
      external_memory_interface_high |-> pin_out[3][4:0] == p4_latch[4:0])
      else $error("port 4 low bits lost their latch");

   port4_bit_a: assert property (
      bitwr_p4 |=> ((p4_latch ^ {8{$past(sfr_in.wdata[0])}})
         & $past(bit_sel)) == 8'h00)
      else $error("port 4 bit write lost");

   page_hit_a: assert property (
      wr_mode_off |-> !sfr_hit_out)
      else $error("output mode hit off page F");

   rmw_c: cover property (rmw_p1 ##1 sfr_rvalid_out);
   ext_read_c: cover property (external_memory_interface_low && external_memory_interface_in.read);
   bit_write_c: cover property (bitwr_p2 && page_f);
   analog_c: cover property (rd_p3 && p3_mode != 8'hFF);
   strobes_c: cover property (external_memory_interface_high);

endmodule

`default_nettype wire

// file: pin_world.sv
// board around ports 1 to 4: outside drivers, pullups, floating lines
// assumes the block's pin outputs are combinational and settled
`default_nettype none

module pin_world (
   input wire logic clock_in,
   input wire port_pin_pkg::port_bus_t value_in,
   input wire port_pin_pkg::port_bus_t oe_in,
   input wire port_pin_pkg::port_bus_t pullup_in,
   input wire port_pin_pkg::port_bus_t ext_en_in,
   input wire port_pin_pkg::port_bus_t ext_in,
   output port_pin_pkg::port_bus_t level_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import port_pin_pkg::*;

   // ********************
   // pin levels
   // ********************
   port_bus_t low;
   port_bus_t high;
   port_bus_t idle;
   logic churn_q = 1'b0;

   // a released line with no pullup and no outside driver churns every cycle
   always_ff @(posedge clock_in) begin
      churn_q <= ~churn_q;
   end

   assign low = oe_in & ~value_in;
   assign high = oe_in & value_in;
   assign idle = pullup_in | {32{churn_q}};
   assign level_out = ~low & (high | (ext_en_in & ext_in)
      | (~ext_en_in & idle));
endmodule

`default_nettype wire

// file: test_port_pin_config.sv
// self-checking bench for the port latch and mode block
// assumes pin_world models the board around the pins
`default_nettype none

module test_port_pin_config;
   timeunit 1ns;
   timeprecision 100ps;
   import port_pin_pkg::*;

   // ********************
   // signals
   // ********************
   localparam logic [7:0] F = 8'h0F;
   localparam logic [7:0] ADR [13] = '{8'hA5, 8'hA6, 8'hA7, 8'h9C,
      8'hE3, 8'hAD, 8'hAE, 8'hAF, 8'h90, 8'hA0, 8'hB0, 8'hC8, 8'h01};
   logic clock_in = 1'b0;
   logic arst_n_in = 1'b0;
   sfr_req_t sfr = '0;
   external_memory_interface_t external_memory_interface = '0;
   port_bus_t force_od = '0;
   port_bus_t ext_en = '0;
   port_bus_t ext = '0;
   port_bus_t lvl, po, oe, pu, skip;
   logic hit, rvalid, hit_seen;
   logic [7:0] rdata;
   int n_mismatch = 0;
   int n_compared = 0;

   port_pin_config i_dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .sfr_in(sfr), .sfr_hit_out(hit), .sfr_rvalid_out(rvalid),
      .sfr_rdata_out(rdata), .external_memory_interface_in(external_memory_interface), .force_od_in(force_od),
      .pin_in(lvl), .pin_out(po), .pin_oe_out(oe), .pullup_out(pu),
      .crossbar_skip_out(skip));

   pin_world i_world (.clock_in(clock_in), .value_in(po), .oe_in(oe),
      .pullup_in(pu), .ext_en_in(ext_en), .ext_in(ext), .level_out(lvl));

   // ********************
   // shared tasks
   // ********************
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [7:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic acc(input logic [3:0] c, input logic [7:0] pg, a, d);
      @(negedge clock_in);
      sfr <= {c, pg, a, d};
      #1 hit_seen = hit;
      @(negedge clock_in);
      sfr <= '0;
   endtask

   task automatic wr(input logic [7:0] pg, a, d);
      acc(4'h4, pg, a, d);
   endtask

   task automatic rd(input string nm, input logic [3:0] c,
         input logic [7:0] pg, a, exp);
      acc(c, pg, a, 8'h00);
      check({nm, " valid"}, 8'h01, {7'h00, rvalid});
      check(nm, exp, rdata);
   endtask

   task automatic settle;
      repeat (10) @(negedge clock_in);
   endtask

   // ********************
   // scenarios
   // ********************
   task automatic s_reset;
      for (int p = 0; p < 4; p++) begin
         check("reset oe", 8'h00, oe[p]);
         check("reset pullup", 8'hFF, pu[p]);
         check("reset out", 8'hFF, po[p]);
      end
      for (int i = 0; i < 13; i++) begin
         logic [3:0] c;
         logic [7:0] e;
         c = (i inside {[8:11]}) ? 4'h9 : 4'h8;
         e = (i inside {[5:11]}) ? 8'hFF : 8'h00;
         rd("reset read", c, F, ADR[i], e);
      end
      check("unmapped hit", 8'h00, {7'h00, hit_seen});
   endtask

   task automatic s_drive;
      wr(F, 8'h90, 8'h5A);
      wr(F, 8'hA5, 8'hF0);
      check("drive oe", 8'hF5, oe[0]);
      check("drive out", 8'h5A, po[0]);
      check("drive pullup", 8'h5A, pu[0]);
      @(negedge clock_in);
      force_od[0] <= 8'hF0;
      #1 check("forced oe", 8'hA5, oe[0]);
      @(negedge clock_in);
      force_od[0] <= 8'h00;
   endtask

   task automatic s_read;
      wr(F, 8'h90, 8'hFF);
      wr(F, 8'hA5, 8'h00);
      ext_en[0] = 8'hFF;
      ext_en[3] = 8'hFF;
      ext[0] = 8'h3C;
      ext[3] = 8'hA5;
      settle();
      rd("pin read", 4'h8, F, 8'h90, 8'h3C);
      rd("latch read", 4'h9, F, 8'h90, 8'hFF);
      rd("port4 pin read", 4'h8, F, 8'hC8, 8'hA5);
      ext_en = '0;
   endtask

   task automatic s_analog;
      wr(F, 8'hAF, 8'h0F);
      wr(F, 8'hAE, 8'h00);
      check("analog pullup", 8'h0F, pu[2]);
      check("analog skip", 8'hF0, skip[2]);
      check("port2 skip", 8'hFC, skip[1]);
      check("port2 pullup", 8'h00, pu[1]);
      ext_en[2] = 8'hFF;
      ext[2] = 8'hFF;
      settle();
      rd("analog read", 4'h8, F, 8'hB0, 8'h0F);
      ext_en = '0;
      wr(F, 8'hAF, 8'hFF);
      wr(F, 8'hAE, 8'hFF);
      check("digital pullup", 8'hFF, pu[2]);
   endtask

   task automatic s_pud;
      wr(F, 8'hE3, 8'hA2);
      rd("crossbar cfg", 4'h8, F, 8'hE3, 8'h82);
      for (int p = 0; p < 4; p++) begin
         check("pullup off", 8'h00, pu[p]);
      end
   endtask

   task automatic s_page;
      wr(8'h00, 8'hA6, 8'hFF);
      check("page hit", 8'h00, {7'h00, hit_seen});
      rd("page refused", 4'h8, F, 8'hA6, 8'h00);
      wr(8'h00, 8'hA0, 8'h0F);
      check("any page", 8'h0F, po[1]);
      wr(8'h00, 8'hC8, 8'h00);
      rd("port4 page", 4'h9, F, 8'hC8, 8'hFF);
      rd("page read", 4'h8, 8'h00, 8'hAF, 8'h00);
      wr(F, 8'hA0, 8'hFF);
   endtask

   task automatic s_bit;
      acc(4'h6, F, 8'hCB, 8'h00);
      check("bit write", 8'hF7, po[3]);
      rd("bit read", 4'hB, F, 8'hCB, 8'h00);
      acc(4'h6, F, 8'hCB, 8'h01);
      check("bit set", 8'hFF, po[3]);
      acc(4'h6, F, 8'hA2, 8'h00);
      check("port2 bit", 8'hFB, po[1]);
      acc(4'h6, F, 8'hA2, 8'h01);
      check("port2 bit set", 8'hFF, po[1]);
      wr(F, 8'hC8, 8'h00);
      check("byte write", 8'h00, po[3]);
      wr(F, 8'hC8, 8'hFF);
   endtask

   task automatic s_external_memory_interface;
      wr(F, 8'hE3, 8'h00);
      @(negedge clock_in);
      external_memory_interface <= {4'hE, 16'h1234, 8'hA5, 3'b110};
      #1 check("mux addr", 8'h12, po[1]);
      check("mux data", 8'hA5, po[2]);
      @(negedge clock_in);
      external_memory_interface <= {4'hD, 16'h1234, 8'hA5, 3'b110};
      #1 check("addr low", 8'h34, po[1]);
      check("read drivers", 8'h00, oe[2]);
      @(negedge clock_in);
      external_memory_interface <= {4'h8, 16'h1234, 8'hA5, 3'b011};
      #1 check("strobes", 8'h03, {5'h00, po[3][7:5]});
      check("latch bits", 8'h1F, {3'h0, po[3][4:0]});
      @(negedge clock_in);
      external_memory_interface <= '0;
      rd("modes kept", 4'h8, F, 8'hA7, 8'h00);
   endtask

   task automatic s_rereset;
      wr(F, 8'hA6, 8'hFF);
      check("push-pull oe", 8'hFF, oe[1]);
      @(negedge clock_in);
      arst_n_in = 1'b0;
      repeat (3) @(negedge clock_in);
      arst_n_in = 1'b1;
      check("rereset oe", 8'h00, oe[1]);
      check("rereset out", 8'hFF, po[1]);
      rd("rereset mode", 4'h8, F, 8'hA6, 8'h00);
   endtask

   // ********************
   // run
   // ********************
   initial begin
      forever #2.5 clock_in = ~clock_in;
   end

   initial begin
      repeat (3) @(negedge clock_in);
      arst_n_in = 1'b1;
      s_reset();
      s_drive();
      s_read();
      s_analog();
      s_pud();
      s_page();
      s_bit();
      s_external_memory_interface();
      s_rereset();
      stop_test();
   end

   initial begin
      #200us;
      n_mismatch++;
      stop_test();
   end
endmodule

`default_nettype wire
